/* File: inc/rtf_pkg.sv */
// Package of constants shared by the relay timer function blocks
package rtf_pkg;

  // Core clock and shared timebase
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_MS = 10;
  localparam int TICK_CYCLES = (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

  // Smallest delay that gives defined timing, in timebase ticks
  localparam int MIN_DELAY_MS = 100;
  localparam int MIN_DELAY_TICKS = MIN_DELAY_MS / TICK_PERIOD_MS;

  // Delay width and count of delay settings
  localparam int DELAY_WIDTH = 16;
  localparam int NUM_DELAYS = 5;

  // Index of each delay setting and of its timer
  localparam int IDX_ON = 0;
  localparam int IDX_OFF = 1;
  localparam int IDX_SW_ON = 2;
  localparam int IDX_SW_OFF = 3;
  localparam int IDX_RET = 4;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DELAY_BASE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // Control register fields
  localparam int CTRL_LATCH_RETAIN = 0;
  localparam int CTRL_POWER_FAIL = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status register field positions
  localparam int STAT_OUT_LSB = 0;
  localparam int STAT_STARTED = 8;
  localparam int STAT_LATCH_MEM = 9;

  // Reset value of every delay setting
  localparam logic [DELAY_WIDTH-1:0] DELAY_RESET = 16'h000a;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: src/rtf_delay_timer.sv */
// Elapsed time counter for one delay block, advanced by the shared tick
`timescale 1ns/1ns
module rtf_delay_timer
  import rtf_pkg::*;
#(
  parameter int Width = DELAY_WIDTH
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic clear,
  input wire logic run,
  input wire logic [Width-1:0] limit,
  output logic [Width-1:0] elapsed,
  output logic reached
);

  logic [Width-1:0] elapsedQ;

  // Clear wins over counting; counting halts on equality, so the count wraps only when the limit is lowered below it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      elapsedQ <= '0;
    end else if (clear) begin
      elapsedQ <= '0;
    end else if (run && tick && (elapsedQ != limit)) begin
      elapsedQ <= elapsedQ + 1'b1;
    end
  end

  assign elapsed = elapsedQ;
  // Equality compare only; a limit lowered below a running count is met only after the count wraps
  assign reached = (elapsedQ == limit);

endmodule

/* File: src/relay_timer_functions.sv */
// Relay timer and latch function blocks with an AXI4-Lite register slave
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ns

// Function
// - On-delay: trigger rising edge restarts elapsed time from zero.
// - On-delay: output rises when elapsed time reaches delay with trigger held high.
// - On-delay: trigger low clears elapsed time and holds output low.
// - Power failure clears elapsed time of every delay block.
// - Off-delay: output rises one cycle after the trigger goes high.
// - Off-delay: falling trigger starts timing; output drops when time equals delay.
// - Off-delay: new trigger pulse restarts timing, lengthening the high output.
// - Off-delay: reset input clears elapsed time and forces output low.
// - On/off: rising edge starts switch-on delay; early fall clears time.
// - On/off: falling edge starts switch-off delay; early rise clears time.
// - Retentive: rising edge starts timing; output set once delay reached.
// - Retentive: later trigger changes, including going low, leave timing untouched.
// - Retentive: only reset input high or power loss clears output and elapsed time.
// - Latch: set with reset low drives output high; reset drives it low.
// - Latch: set and reset together give reset priority, output low.
// - Latch has a setting enabling output retention across power loss.
// - Latch holds its output while set and reset are both low.
// - After power returns latch restores old output only when retention enabled.
module relay_timer_functions
  import rtf_pkg::*;
#(
  parameter int TickCycles = TICK_CYCLES,
  parameter int DelayWidth = DELAY_WIDTH
) (
  input wire logic core_clk,
  input wire logic rst_b,
  // AXI4-Lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Logic network inputs
  input wire logic powerFail,
  input wire logic onTrg,
  input wire logic offTrg,
  input wire logic offRst,
  input wire logic onOffTrg,
  input wire logic retTrg,
  input wire logic retRst,
  input wire logic latchSet,
  input wire logic latchRst,
  // Block outputs
  output logic onQ,
  output logic offQ,
  output logic onOffQ,
  output logic retQ,
  output logic latchQ
);

  // Returns the delay index addressed, or NUM_DELAYS when not a delay register
  function automatic int delayIndex(input logic [7:0] addr);
    int idx;
    idx = int'(addr[7:2]) - int'(ADDR_DELAY_BASE[7:2]);
    return (idx >= 0 && idx < NUM_DELAYS) ? idx : NUM_DELAYS;
  endfunction

  // Applies byte strobes to a register value
  function automatic logic [31:0] strobeMerge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Bus state, settings, timebase and block state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, awHeld_q, wHeld_q, doWrite;
  logic [1:0] bresp_q, rresp_q, ctrl_q;
  logic [7:0] awAddr_q;
  logic [31:0] rdata_q, wData_q, tickCnt_q;
  logic [3:0] wStrb_q;
  int wrIdx, rdIdx;
  logic [DelayWidth-1:0] delay_q [NUM_DELAYS];
  logic tick_q, pwrLost, latchRetain, retStarted_q, latchMem_q;
  logic onTrgPrev_q, offTrgPrev_q, onOffTrgPrev_q, retTrgPrev_q;
  logic onQ_q, offQ_q, onOffQ_q, retQ_q, latchQ_q;
  logic [NUM_DELAYS-1:0] tmrClear, tmrRun, tmrReached;
  logic onRise, offFall, onOffRise, onOffFall, retRise, onOffSet, onOffDrop;

  // Write address and data are taken independently, then committed together
  assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
  assign wrIdx = delayIndex(awAddr_q);
  assign rdIdx = delayIndex(araddr);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      awready_q <= 1'b0;
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
    end else if (awvalid && awready_q) begin
      awready_q <= 1'b0;
      awHeld_q <= 1'b1;
      awAddr_q <= awaddr;
    end else if (doWrite) begin
      awHeld_q <= 1'b0;
    end else if (!awHeld_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wready_q <= 1'b0;
      wHeld_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end else if (wvalid && wready_q) begin
      wready_q <= 1'b0;
      wHeld_q <= 1'b1;
      wData_q <= wdata;
      wStrb_q <= wstrb;
    end else if (doWrite) begin
      wHeld_q <= 1'b0;
    end else if (!wHeld_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  // Write response; unmapped and read-only addresses answer with an error
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid_q <= 1'b1;
      if (awAddr_q[7:2] == ADDR_CTRL[7:2] || wrIdx < NUM_DELAYS) begin
        bresp_q <= RESP_OKAY;
      end else begin
        bresp_q <= RESP_SLVERR;
      end
    end else if (bvalid_q && bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Control register: latch retention and software power-fail request
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RESET;
    end else if (doWrite && awAddr_q[7:2] == ADDR_CTRL[7:2]) begin
      ctrl_q <= 2'(strobeMerge({30'h0, ctrl_q}, wData_q, wStrb_q));
    end
  end

  // Delay settings, kept at their documented minimum after reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_DELAYS; i++) begin
        delay_q[i] <= DELAY_RESET;
      end
    end else if (doWrite && wrIdx < NUM_DELAYS) begin
      delay_q[wrIdx] <= DelayWidth'(strobeMerge(32'(delay_q[wrIdx]), wData_q, wStrb_q));
    end
  end

  // Read channel, one cycle from address to data
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      if (araddr[7:2] == ADDR_CTRL[7:2]) begin
        rdata_q <= {30'h0, ctrl_q};
      end else if (araddr[7:2] == ADDR_STATUS[7:2]) begin
        rdata_q <= 32'h0000_0000;
        rdata_q[STAT_OUT_LSB +: 5] <= {latchQ_q, retQ_q, onOffQ_q, offQ_q, onQ_q};
        rdata_q[STAT_STARTED] <= retStarted_q;
        rdata_q[STAT_LATCH_MEM] <= latchMem_q;
      end else if (rdIdx < NUM_DELAYS) begin
        rdata_q <= 32'(delay_q[rdIdx]);
      end else begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= RESP_SLVERR;
      end
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // Shared timebase; the period is a parameter so simulation can shorten it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (tickCnt_q == 32'(TickCycles - 1)) begin
      tickCnt_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  assign pwrLost = powerFail || ctrl_q[CTRL_POWER_FAIL];
  assign latchRetain = ctrl_q[CTRL_LATCH_RETAIN];

  // Previous trigger levels for edge detection
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      onTrgPrev_q <= 1'b0;
      offTrgPrev_q <= 1'b0;
      onOffTrgPrev_q <= 1'b0;
      retTrgPrev_q <= 1'b0;
    end else begin
      onTrgPrev_q <= onTrg;
      offTrgPrev_q <= offTrg;
      onOffTrgPrev_q <= onOffTrg;
      retTrgPrev_q <= retTrg;
    end
  end

  assign onRise = onTrg && !onTrgPrev_q;
  assign offFall = !offTrg && offTrgPrev_q;
  assign onOffRise = onOffTrg && !onOffTrgPrev_q;
  assign onOffFall = !onOffTrg && onOffTrgPrev_q;
  assign retRise = retTrg && !retTrgPrev_q;

  // On/off output changes when the phase delay runs out with the trigger held
  assign onOffSet = !onOffQ_q && onOffTrg && !onOffRise && tmrReached[IDX_SW_ON];
  assign onOffDrop = onOffQ_q && !onOffTrg && !onOffFall && tmrReached[IDX_SW_OFF];

  // Timer steering; power loss clears every elapsed time
  always_comb begin
    tmrClear[IDX_ON] = pwrLost || !onTrg || onRise;
    tmrRun[IDX_ON] = onTrg;
    tmrClear[IDX_OFF] = pwrLost || offRst || offTrg || offFall;
    tmrRun[IDX_OFF] = !offTrg && offQ_q;
    // Each on/off phase has its own timer so the two delays never mix
    tmrClear[IDX_SW_ON] = pwrLost || onOffQ_q || !onOffTrg || onOffRise;
    tmrRun[IDX_SW_ON] = !onOffQ_q && onOffTrg;
    tmrClear[IDX_SW_OFF] = pwrLost || !onOffQ_q || onOffTrg || onOffFall;
    tmrRun[IDX_SW_OFF] = onOffQ_q && !onOffTrg;
    tmrClear[IDX_RET] = pwrLost || retRst;
    tmrRun[IDX_RET] = retStarted_q;
  end

  // One elapsed time counter per delay setting, two for the on/off block
  for (genvar g = 0; g < NUM_DELAYS; g++) begin : gTimer
    rtf_delay_timer #(
      .Width(DelayWidth)
    ) uTimer (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .tick(tick_q),
      .clear(tmrClear[g]),
      .run(tmrRun[g]),
      .limit(delay_q[g]),
      .elapsed(),
      .reached(tmrReached[g])
    );
  end

  // On-delay output, low whenever the trigger is low
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      onQ_q <= 1'b0;
    end else begin
      onQ_q <= !pwrLost && onTrg && !onRise && tmrReached[IDX_ON];
    end
  end

  // Off-delay output; reset has priority over a high trigger
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      offQ_q <= 1'b0;
    end else if (pwrLost || offRst) begin
      offQ_q <= 1'b0;
    end else if (offTrg) begin
      offQ_q <= 1'b1;
    end else if (!offFall && tmrReached[IDX_OFF]) begin
      offQ_q <= 1'b0;
    end
  end

  // On/off-delay output
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      onOffQ_q <= 1'b0;
    end else if (pwrLost) begin
      onOffQ_q <= 1'b0;
    end else if (onOffSet) begin
      onOffQ_q <= 1'b1;
    end else if (onOffDrop) begin
      onOffQ_q <= 1'b0;
    end
  end

  // Retentive on-delay: once started, only reset or power loss stops it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      retStarted_q <= 1'b0;
      retQ_q <= 1'b0;
    end else if (pwrLost || retRst) begin
      retStarted_q <= 1'b0;
      retQ_q <= 1'b0;
    end else begin
      if (retRise) begin
        retStarted_q <= 1'b1;
      end
      if (retStarted_q && tmrReached[IDX_RET]) begin
        retQ_q <= 1'b1;
      end
    end
  end

  // Latch memory; without retention the stored state is lost with power
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      latchMem_q <= 1'b0;
    end else if (pwrLost) begin
      if (!latchRetain) begin
        latchMem_q <= 1'b0;
      end
    end else if (latchRst) begin
      latchMem_q <= 1'b0;
    end else if (latchSet) begin
      latchMem_q <= 1'b1;
    end
  end

  // Latch output takes the memory's next state, but stays low while power is away
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      latchQ_q <= 1'b0;
    end else begin
      latchQ_q <= !pwrLost && !latchRst && (latchSet || latchMem_q);
    end
  end

  // Every output is a register; the ports only rename them
  assign {awready, wready, bvalid, bresp} = {awready_q, wready_q, bvalid_q, bresp_q};
  assign {arready, rvalid, rdata, rresp} = {arready_q, rvalid_q, rdata_q, rresp_q};
  assign {onQ, offQ, onOffQ, retQ, latchQ} = {onQ_q, offQ_q, onOffQ_q, retQ_q, latchQ_q};

endmodule

/* File: testbench/rtf_checker_properties.sv */
// Checker of the timer and latch outputs at the block ports
`timescale 1ns/1ns
module rtf_checker
  import rtf_pkg::*;
#(
  parameter int TickCycles = TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic powerFail,
  input wire logic onTrg,
  input wire logic offTrg,
  input wire logic offRst,
  input wire logic retRst,
  input wire logic latchSet,
  input wire logic latchRst,
  input wire logic onQ,
  input wire logic offQ,
  input wire logic onOffQ,
  input wire logic retQ,
  input wire logic latchQ
);
  int onHigh_q;

  // Length of the current on-delay trigger pulse, to prove the output waited
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      onHigh_q <= 0;
    end else begin
      onHigh_q <= onTrg ? onHigh_q + 1 : 0;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // Outputs follow their causes one edge later
  a_on_low: assert property (!onTrg |=> !onQ) else $error("onQ high, trigger low");
  a_on_wait: assert property ($rose(onQ) |->
    onHigh_q >= (MIN_DELAY_TICKS - 1) * TickCycles) else $error("onQ rose early");
  a_off_follow: assert property (offTrg && !offRst && !powerFail |=> offQ)
    else $error("offQ not following trigger");
  a_off_hold: assert property ($fell(offTrg) && !offRst && !powerFail |=> offQ [*4])
    else $error("offQ dropped at trigger fall");
  a_off_reset: assert property (offRst |=> !offQ) else $error("offQ high in reset");
  a_latch_set: assert property (latchSet && !latchRst && !powerFail |=> latchQ)
    else $error("latch not set");
  a_latch_prio: assert property (latchRst |=> !latchQ) else $error("latch not reset");
  a_latch_hold: assert property (!latchSet && !latchRst && !powerFail &&
    !$past(powerFail) |=> $stable(latchQ)) else $error("latch changed while idle");
  a_ret_hold: assert property (retQ && !retRst && !powerFail |=> retQ)
    else $error("retQ lost without reset");
  a_power_clear: assert property (powerFail |=>
    !(onQ || offQ || onOffQ || retQ || latchQ)) else $error("output high in outage");
endmodule

bind relay_timer_functions rtf_checker #(.TickCycles(TickCycles)) u_rtf_checker (
  .core_clk(core_clk), .rst_b(rst_b), .powerFail(powerFail), .onTrg(onTrg),
  .offTrg(offTrg), .offRst(offRst), .retRst(retRst), .latchSet(latchSet),
  .latchRst(latchRst), .onQ(onQ), .offQ(offQ), .onOffQ(onOffQ), .retQ(retQ),
  .latchQ(latchQ)
);

/* File: testbench/rtf_net_model.sv */
// Model of the user logic network that feeds the function block inputs
`timescale 1ns/1ns
module rtf_net_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] netCmd,
  output logic [7:0] netOut_q
);
  // Network result settles once per scan, so inputs never glitch mid-cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      netOut_q <= 8'h00;
    end else begin
      netOut_q <= netCmd;
    end
  end
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the relay timer function blocks
`timescale 1ns/1ns
module tb;
  import rtf_pkg::*;
  localparam int TC = 4;
  localparam int D = 12;
  localparam int LO = (D - 1) * TC;
  localparam int HI = (D + 1) * TC + 6;
  logic core_clk, rst_b, awvalid, wvalid, bready, arvalid, rready, powerFail;
  logic awready, wready, bvalid, arready, rvalid, onQ, offQ, onOffQ, retQ, latchQ;
  logic [7:0] awaddr, araddr, netCmd, netOut_q;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [4:0] qv;
  int err_total = 0;
  int num_checks = 0;
  assign qv = {latchQ, retQ, onOffQ, offQ, onQ};

  relay_timer_functions #(.TickCycles(TC), .DelayWidth(DELAY_WIDTH)) u_relay_timer_functions (
    .core_clk(core_clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .powerFail(powerFail), .onTrg(netOut_q[0]),
    .offTrg(netOut_q[1]), .offRst(netOut_q[2]), .onOffTrg(netOut_q[3]),
    .retTrg(netOut_q[4]), .retRst(netOut_q[5]), .latchSet(netOut_q[6]),
    .latchRst(netOut_q[7]), .onQ(onQ), .offQ(offQ), .onOffQ(onOffQ), .retQ(retQ),
    .latchQ(latchQ)
  );
  rtf_net_model u_rtf_net_model (
    .core_clk(core_clk), .rst_b(rst_b), .netCmd(netCmd), .netOut_q(netOut_q)
  );

  // Free-running core clock
  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic hang(input string nm);
    err_total++;
    $display("ERROR %s expected answer seen timeout", nm);
    stop_test();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One network bit per edge, so no signal is driven twice in a step
  task automatic net(input int b, input logic v);
    @(posedge core_clk);
    netCmd[b] <= v;
  endtask
  // Cycles until an output settles at a level, judged against a window
  task automatic wait_q(input string nm, input int i, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (qv[i] !== v) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > hi) hang(nm);
    end
    chk(nm, 32'h1, 32'(n >= lo));
  endtask
  // Bus master: address and data offered together, response awaited
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      n++;
      if (n > 40) hang("bvalid");
    end while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'h0;
      n++;
      if (n > 40) hang("rvalid");
    end while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(ADDR_CTRL, d, r);
    chk("ctrl reset", 32'h0, d);
    for (int i = 0; i < NUM_DELAYS; i++) begin
      axi_rd(ADDR_DELAY_BASE + 8'(4 * i), d, r);
      chk("delay reset", 32'(DELAY_RESET), d);
      axi_wr(ADDR_DELAY_BASE + 8'(4 * i), 32'(D), r);
      axi_rd(ADDR_DELAY_BASE + 8'(4 * i), d, r);
      chk("delay readback", 32'(D), d);
    end
    axi_rd(8'h1c, d, r);
    chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
    chk("unmapped rdata", 32'h0, d);
    axi_wr(ADDR_STATUS, 32'h1f, r);
    chk("status bresp", 32'(RESP_SLVERR), 32'(r));
    $display("test regs done");
  endtask
  task automatic t_on();
    logic [1:0] r;
    net(0, 1'h1);
    cyc(D * TC / 2);
    net(0, 1'h0);
    cyc(D * TC);
    chk("onQ short pulse", 32'h0, 32'(onQ));
    net(0, 1'h1);
    wait_q("onQ delay", 0, 1'h1, LO, HI);
    net(0, 1'h0);
    wait_q("onQ trg low", 0, 1'h0, 0, 4);
    // Software outage mid-count: timing must restart from zero afterwards
    net(0, 1'h1);
    cyc(D * TC / 2);
    axi_wr(ADDR_CTRL, 32'h2, r);
    axi_wr(ADDR_CTRL, 32'h0, r);
    wait_q("onQ after outage", 0, 1'h1, LO - 4, HI);
    net(0, 1'h0);
    cyc(3);
    $display("test on delay done");
  endtask
  task automatic t_off();
    net(1, 1'h1);
    wait_q("offQ rise", 1, 1'h1, 0, 4);
    net(1, 1'h0);
    cyc(D * TC / 2);
    chk("offQ held", 32'h1, 32'(offQ));
    net(1, 1'h1);
    net(1, 1'h0);
    wait_q("offQ retrig", 1, 1'h0, LO, HI);
    net(1, 1'h1);
    net(1, 1'h0);
    cyc(8);
    net(2, 1'h1);
    wait_q("offQ reset", 1, 1'h0, 0, 4);
    net(2, 1'h0);
    $display("test off delay done");
  endtask
  task automatic t_onoff();
    net(3, 1'h1);
    wait_q("onOffQ on", 2, 1'h1, LO, HI);
    net(3, 1'h0);
    cyc(D * TC / 2);
    net(3, 1'h1);
    cyc(D * TC);
    chk("onOffQ held", 32'h1, 32'(onOffQ));
    net(3, 1'h0);
    wait_q("onOffQ off", 2, 1'h0, LO, HI);
    $display("test on/off delay done");
  endtask
  task automatic t_ret();
    logic [31:0] d;
    logic [1:0] r;
    net(4, 1'h1);
    cyc(3);
    net(4, 1'h0);
    wait_q("retQ set", 3, 1'h1, LO - 4, HI);
    net(4, 1'h1);
    cyc(D * TC);
    chk("retQ hold", 32'h1, 32'(retQ));
    axi_rd(ADDR_STATUS, d, r);
    chk("status", 32'((1 << (STAT_OUT_LSB + 3)) | (1 << STAT_STARTED)), d);
    net(5, 1'h1);
    wait_q("retQ clear", 3, 1'h0, 0, 4);
    net(5, 1'h0);
    net(4, 1'h0);
    $display("test retentive done");
  endtask
  // Outage of a few cycles; the latch output must be cleared meanwhile
  task automatic pwr_cycle();
    @(posedge core_clk);
    powerFail <= 1'h1;
    cyc(4);
    chk("latch in outage", 32'h0, 32'(latchQ));
    powerFail <= 1'h0;
    cyc(4);
  endtask
  task automatic t_latch();
    logic [1:0] r;
    net(6, 1'h1);
    wait_q("latch set", 4, 1'h1, 0, 4);
    net(6, 1'h0);
    cyc(5);
    chk("latch hold", 32'h1, 32'(latchQ));
    net(6, 1'h1);
    net(7, 1'h1);
    wait_q("latch both", 4, 1'h0, 0, 4);
    net(6, 1'h0);
    net(7, 1'h0);
    axi_wr(ADDR_CTRL, 32'h1, r);
    net(6, 1'h1);
    net(6, 1'h0);
    pwr_cycle();
    chk("latch kept", 32'h1, 32'(latchQ));
    axi_wr(ADDR_CTRL, 32'h0, r);
    pwr_cycle();
    chk("latch lost", 32'h0, 32'(latchQ));
    $display("test latch done");
  endtask

  // Main sequence
  initial begin
    rst_b = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready, powerFail} = 6'h00;
    {awaddr, araddr, wdata, wstrb, netCmd} = 60'h0;
    cyc(5);
    rst_b <= 1'h1;
    cyc(2);
    t_regs();
    t_on();
    t_off();
    t_onoff();
    t_ret();
    t_latch();
    stop_test();
  end
endmodule
